// ### core/jfp_pkg.sv
// constants, codes and types of the scan-port flash programming front end
// Contract
// - instruction register is four bits wide, sixteen codes
// - every scan shift register moves least significant bit first
// - programming needs enable fuse programmed and disable bit cleared
// - disable bit set with external reset low clears after two clocks
// - code 0xC selects one-bit reset chain; TAP not reset by it
// - reset chain holding one keeps the target in reset, unlatched
// - after chain release target stays reset for fuse-selected time-out
// - code 0x4 selects the 16-bit unlock signature register
// - update compares signature 0xA370; exact match enters programming mode
// - unlock register clears on power-on; programmer clears it on exit
// - code 0x5 selects the 15-bit command shift register
// - capture loads previous result, shift outputs it while new enters
// - update applies command; each run-test/idle makes one command clock
// - code 0x6 selects 8-bit byte register, low bits of command register
// - page-load update copies byte to holder, writes buffer within 11 clocks
// - page-load writes alternate low then high, low first after entry
// - counter increments before each low write except the first; the code pulses it in the same cycle as that write
// - code 0x7 captures flash byte per capture, low then high
// - page read increments counter after every high byte read
package jfp_pkg;

  localparam int IR_W     = 4;
  localparam int CMD_W    = 15;
  localparam int UNLOCK_W = 16;
  localparam int BYTE_W   = 8;
  localparam int WORD_W   = 16;

  // instruction codes
  localparam logic [IR_W-1:0] TARGET_RESET_INSTR   = 4'hC;
  localparam logic [IR_W-1:0] PROGRAM_UNLOCK_INSTR = 4'h4;
  localparam logic [IR_W-1:0] PROGRAM_COMMAND_INSTR = 4'h5;
  localparam logic [IR_W-1:0] PAGE_LOAD_INSTR      = 4'h6;
  localparam logic [IR_W-1:0] PAGE_READ_INSTR      = 4'h7;
  localparam logic [IR_W-1:0] BYPASS_INSTR         = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL       = 4'h1;

  localparam logic [UNLOCK_W-1:0] UNLOCK_SIGNATURE = 16'hA370;
  localparam logic [UNLOCK_W-1:0] UNLOCK_RESET_VAL = 16'h0000;
  localparam logic [CMD_W-1:0]    CMD_RESET_VAL    = 15'h0000;
  localparam logic                DISABLE_RESET_VAL = 1'b0;

  // disable-bit clearing after external reset held low, in chip clocks
  localparam logic [1:0] DISABLE_CLEAR_CLOCKS = 2'h2;

  // reset time-out options selected by the clock-option fuses
  localparam int REF_CLK_HZ    = 40_000_000;
  localparam int CYCLES_PER_US = REF_CLK_HZ / 1_000_000;
  localparam int TIMEOUT_OPT0_US = 1;
  localparam int TIMEOUT_OPT1_US = 4;
  localparam int TIMEOUT_OPT2_US = 16;
  localparam int TIMEOUT_OPT3_US = 64;
  localparam int TMO_W = 12;
  localparam logic [TMO_W-1:0] TIMEOUT_OPT0_CYC = TMO_W'(TIMEOUT_OPT0_US * CYCLES_PER_US);
  localparam logic [TMO_W-1:0] TIMEOUT_OPT1_CYC = TMO_W'(TIMEOUT_OPT1_US * CYCLES_PER_US);
  localparam logic [TMO_W-1:0] TIMEOUT_OPT2_CYC = TMO_W'(TIMEOUT_OPT2_US * CYCLES_PER_US);
  localparam logic [TMO_W-1:0] TIMEOUT_OPT3_CYC = TMO_W'(TIMEOUT_OPT3_US * CYCLES_PER_US);

  // test access port controller states
  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE,
    SEL_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SEL_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } jfp_tap_state_type;

endpackage

// ### core/jfp_tap_fsm.sv
// test access port controller advanced on each sampled test clock rise
`timescale 1ns/1ps
`default_nettype none
module jfp_tap_fsm (
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire logic                  tck_rise,
  input  wire logic                  tms,
  input  wire logic                  hold_reset,
  output var  jfp_pkg::jfp_tap_state_type state_r
);

  jfp_pkg::jfp_tap_state_type state_nxt;

  // standard sixteen-state walk steered by tms
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      jfp_pkg::TEST_RESET: state_nxt = tms ? jfp_pkg::TEST_RESET : jfp_pkg::RUN_IDLE;
      jfp_pkg::RUN_IDLE:   state_nxt = tms ? jfp_pkg::SEL_DR : jfp_pkg::RUN_IDLE;
      jfp_pkg::SEL_DR:     state_nxt = tms ? jfp_pkg::SEL_IR : jfp_pkg::CAPTURE_DR;
      jfp_pkg::CAPTURE_DR: state_nxt = tms ? jfp_pkg::EXIT1_DR : jfp_pkg::SHIFT_DR;
      jfp_pkg::SHIFT_DR:   state_nxt = tms ? jfp_pkg::EXIT1_DR : jfp_pkg::SHIFT_DR;
      jfp_pkg::EXIT1_DR:   state_nxt = tms ? jfp_pkg::UPDATE_DR : jfp_pkg::PAUSE_DR;
      jfp_pkg::PAUSE_DR:   state_nxt = tms ? jfp_pkg::EXIT2_DR : jfp_pkg::PAUSE_DR;
      jfp_pkg::EXIT2_DR:   state_nxt = tms ? jfp_pkg::UPDATE_DR : jfp_pkg::SHIFT_DR;
      jfp_pkg::UPDATE_DR:  state_nxt = tms ? jfp_pkg::SEL_DR : jfp_pkg::RUN_IDLE;
      jfp_pkg::SEL_IR:     state_nxt = tms ? jfp_pkg::TEST_RESET : jfp_pkg::CAPTURE_IR;
      jfp_pkg::CAPTURE_IR: state_nxt = tms ? jfp_pkg::EXIT1_IR : jfp_pkg::SHIFT_IR;
      jfp_pkg::SHIFT_IR:   state_nxt = tms ? jfp_pkg::EXIT1_IR : jfp_pkg::SHIFT_IR;
      jfp_pkg::EXIT1_IR:   state_nxt = tms ? jfp_pkg::UPDATE_IR : jfp_pkg::PAUSE_IR;
      jfp_pkg::PAUSE_IR:   state_nxt = tms ? jfp_pkg::EXIT2_IR : jfp_pkg::PAUSE_IR;
      jfp_pkg::EXIT2_IR:   state_nxt = tms ? jfp_pkg::UPDATE_IR : jfp_pkg::SHIFT_IR;
      jfp_pkg::UPDATE_IR:  state_nxt = tms ? jfp_pkg::SEL_DR : jfp_pkg::RUN_IDLE;
    endcase
  end

  // a locked-out port is parked in test-logic-reset
  always_ff @(posedge ref_clk) begin
    if (srst || hold_reset) begin
      state_r <= jfp_pkg::TEST_RESET;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

endmodule
`default_nettype wire

// ### core/jfp_prog_port.sv
// scan-port flash programming front end: data registers, unlock and page sequencing
`timescale 1ns/1ps
`default_nettype none
module jfp_prog_port (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output logic                             tdo,
  output logic                             tdo_oe,
  input  wire logic                        ext_reset_n,
  input  wire logic                        scan_port_enable_fuse,
  input  wire logic [1:0]                  clock_option_fuse,
  input  wire logic                        cpu_disable_wr,
  input  wire logic                        cpu_disable_wdata,
  output logic                             scan_port_disable_bit,
  output logic                             target_reset,
  output logic                             prog_mode,
  input  wire logic [jfp_pkg::CMD_W-1:0]   flash_cmd_result,
  output logic [jfp_pkg::CMD_W-1:0]        flash_cmd,
  output logic                             flash_cmd_clk,
  output logic [jfp_pkg::BYTE_W-1:0]       page_wr_data,
  output logic                             page_wr_high,
  output logic                             page_wr_en,
  input  wire logic [jfp_pkg::WORD_W-1:0]  flash_rd_word,
  output logic                             pc_inc
);

  // pin synchronisers; stage one feeds only stage two
  logic [1:0] tck_sync_r, tms_sync_r, tdi_sync_r, rstn_sync_r;
  logic       tck_dly_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tck_sync_r  <= 2'h0;
      tms_sync_r  <= 2'h3;
      tdi_sync_r  <= 2'h0;
      rstn_sync_r <= 2'h3;
      tck_dly_r   <= 1'b0;
    end else begin
      tck_sync_r  <= {tck_sync_r[0], tck};
      tms_sync_r  <= {tms_sync_r[0], tms};
      tdi_sync_r  <= {tdi_sync_r[0], tdi};
      rstn_sync_r <= {rstn_sync_r[0], ext_reset_n};
      tck_dly_r   <= tck_sync_r[1];
    end
  end

  wire tck_s    = tck_sync_r[1];
  wire tms_s    = tms_sync_r[1];
  wire tdi_s    = tdi_sync_r[1];
  wire ext_low  = ~rstn_sync_r[1];
  wire tck_rise = tck_s & ~tck_dly_r;
  wire tck_fall = ~tck_s & tck_dly_r;

  // disable bit and its forced clearing under external reset
  logic       dis_r;
  logic [1:0] dis_cnt_r;
  wire        dis_clear = dis_r && ext_low && (dis_cnt_r == jfp_pkg::DISABLE_CLEAR_CLOCKS - 2'h1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dis_r     <= jfp_pkg::DISABLE_RESET_VAL;
      dis_cnt_r <= 2'h0;
    end else begin
      if (dis_clear) begin
        dis_r <= 1'b0;
      end else if (cpu_disable_wr) begin
        dis_r <= cpu_disable_wdata;
      end
      dis_cnt_r <= (dis_r && ext_low && !dis_clear) ? dis_cnt_r + 2'h1 : 2'h0;
    end
  end

  assign scan_port_disable_bit = dis_r;

  // the port only works with fuse programmed and disable bit clear
  wire port_active = scan_port_enable_fuse & ~dis_r;

  jfp_pkg::jfp_tap_state_type tap_state;

  jfp_tap_fsm u_tap (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .tck_rise   (tck_rise),
    .tms        (tms_s),
    .hold_reset (~port_active),
    .state_r    (tap_state)
  );

  // state decodes qualified by the test clock rise, except in_reset
  wire in_reset   = tap_state == jfp_pkg::TEST_RESET;
  wire do_cap_dr  = tck_rise && tap_state == jfp_pkg::CAPTURE_DR;
  wire do_sh_dr   = tck_rise && tap_state == jfp_pkg::SHIFT_DR;
  wire do_up_dr   = tck_rise && tap_state == jfp_pkg::UPDATE_DR;
  wire do_cap_ir  = tck_rise && tap_state == jfp_pkg::CAPTURE_IR;
  wire do_sh_ir   = tck_rise && tap_state == jfp_pkg::SHIFT_IR;
  wire do_up_ir   = tck_rise && tap_state == jfp_pkg::UPDATE_IR;
  wire do_idle    = tck_rise && tap_state == jfp_pkg::RUN_IDLE;

  // instruction register, four bits
  logic [jfp_pkg::IR_W-1:0] ir_sr_r, ir_r;

  always_ff @(posedge ref_clk) begin
    if (srst || in_reset) begin
      ir_sr_r <= jfp_pkg::IR_CAPTURE_VAL;
      ir_r    <= jfp_pkg::BYPASS_INSTR;
    end else begin
      if (do_cap_ir) begin
        ir_sr_r <= jfp_pkg::IR_CAPTURE_VAL;
      end else if (do_sh_ir) begin
        ir_sr_r <= {tdi_s, ir_sr_r[jfp_pkg::IR_W-1:1]};
      end
      if (do_up_ir) begin
        ir_r <= ir_sr_r;
      end
    end
  end

  wire sel_reset  = ir_r == jfp_pkg::TARGET_RESET_INSTR;
  wire sel_unlock = ir_r == jfp_pkg::PROGRAM_UNLOCK_INSTR;
  wire sel_cmd    = ir_r == jfp_pkg::PROGRAM_COMMAND_INSTR;
  wire sel_load   = ir_r == jfp_pkg::PAGE_LOAD_INSTR;
  wire sel_read   = ir_r == jfp_pkg::PAGE_READ_INSTR;
  wire sel_byte   = sel_load | sel_read;

  // reset chain and bypass bit; the chain is not cleared by TAP reset
  logic chain_r, bypass_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chain_r  <= 1'b0;
      bypass_r <= 1'b0;
    end else begin
      if (do_sh_dr && sel_reset) begin
        chain_r <= tdi_s;
      end
      bypass_r <= do_cap_dr ? 1'b0 : (do_sh_dr ? tdi_s : bypass_r);
    end
  end

  // target reset with time-out after the chain or pin lets go
  logic [jfp_pkg::TMO_W-1:0] tmo_cnt_r;
  wire  [jfp_pkg::TMO_W-1:0] tmo_sel =
    (clock_option_fuse == 2'h0) ? jfp_pkg::TIMEOUT_OPT0_CYC :
    (clock_option_fuse == 2'h1) ? jfp_pkg::TIMEOUT_OPT1_CYC :
    (clock_option_fuse == 2'h2) ? jfp_pkg::TIMEOUT_OPT2_CYC : jfp_pkg::TIMEOUT_OPT3_CYC;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tmo_cnt_r <= '0;
    end else if (chain_r || ext_low) begin
      tmo_cnt_r <= tmo_sel;
    end else if (tmo_cnt_r != '0) begin
      tmo_cnt_r <= tmo_cnt_r - 1'b1;
    end
  end

  // chain output unlatched so reset acts in the same cycle
  assign target_reset = chain_r | ext_low | (tmo_cnt_r != '0);

  // unlock signature register and programming mode
  logic [jfp_pkg::UNLOCK_W-1:0] unlock_sr_r;
  logic                         prog_r;
  wire  sig_match = unlock_sr_r == jfp_pkg::UNLOCK_SIGNATURE;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unlock_sr_r <= jfp_pkg::UNLOCK_RESET_VAL;
      prog_r      <= 1'b0;
    end else begin
      if (do_sh_dr && sel_unlock) begin
        unlock_sr_r <= {tdi_s, unlock_sr_r[jfp_pkg::UNLOCK_W-1:1]};
      end
      if (!port_active) begin
        prog_r <= 1'b0;
      end else if (do_up_dr && sel_unlock) begin
        prog_r <= sig_match;
      end
    end
  end

  assign prog_mode = prog_r;

  // command register; the byte register is its low eight bits
  logic [jfp_pkg::CMD_W-1:0] cmd_sr_r, cmd_app_r;
  logic                      cmd_clk_r;
  logic [jfp_pkg::BYTE_W-1:0] rd_byte;
  logic                      rd_high_r;

  assign rd_byte = rd_high_r ? flash_rd_word[jfp_pkg::WORD_W-1:jfp_pkg::BYTE_W]
                             : flash_rd_word[jfp_pkg::BYTE_W-1:0];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmd_sr_r <= jfp_pkg::CMD_RESET_VAL;
    end else if (do_cap_dr && sel_cmd && prog_r) begin
      cmd_sr_r <= flash_cmd_result;
    end else if (do_cap_dr && sel_read && prog_r) begin
      cmd_sr_r[jfp_pkg::BYTE_W-1:0] <= rd_byte;
    end else if (do_sh_dr && sel_cmd) begin
      cmd_sr_r <= {tdi_s, cmd_sr_r[jfp_pkg::CMD_W-1:1]};
    end else if (do_sh_dr && sel_byte) begin
      cmd_sr_r[jfp_pkg::BYTE_W-1:0] <= {tdi_s, cmd_sr_r[jfp_pkg::BYTE_W-1:1]};
    end
  end

  // applied command and one execution clock per idle tick
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmd_app_r <= jfp_pkg::CMD_RESET_VAL;
      cmd_clk_r <= 1'b0;
    end else begin
      if (do_up_dr && sel_cmd && prog_r) begin
        cmd_app_r <= cmd_sr_r;
      end
      cmd_clk_r <= do_idle && sel_cmd && prog_r;
    end
  end

  assign flash_cmd     = cmd_app_r;
  assign flash_cmd_clk = cmd_clk_r;

  // page-load sequence: hold byte, then write, with any counter step in the write cycle
  logic [jfp_pkg::BYTE_W-1:0] hold_r;
  logic ld_step_r, ld_wr_r, ld_high_r, ld_first_r, pc_inc_r;
  wire  ld_update = do_up_dr && sel_load && prog_r;
  wire  rd_cap    = do_cap_dr && sel_read && prog_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hold_r    <= '0;
      ld_step_r <= 1'b0;
      ld_wr_r   <= 1'b0;
    end else begin
      if (ld_update) begin
        hold_r <= cmd_sr_r[jfp_pkg::BYTE_W-1:0];
      end
      ld_step_r <= ld_update;
      ld_wr_r   <= ld_step_r; // two ref clocks, far inside 11 test clocks
    end
  end

  // byte-lane toggles restart whenever a new instruction is taken
  always_ff @(posedge ref_clk) begin
    if (srst || do_up_ir) begin
      ld_high_r  <= 1'b0;
      ld_first_r <= 1'b1;
      rd_high_r  <= 1'b0;
    end else begin
      if (ld_wr_r) begin
        ld_high_r  <= ~ld_high_r;
        ld_first_r <= 1'b0;
      end
      if (rd_cap) begin
        rd_high_r <= ~rd_high_r;
      end
    end
  end

  // one counter step: in the same cycle as non-first low writes, after each high read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pc_inc_r <= 1'b0;
    end else begin
      pc_inc_r <= (ld_step_r && !ld_high_r && !ld_first_r)
               || (rd_cap && rd_high_r);
    end
  end

  assign page_wr_data = hold_r;
  assign page_wr_high = ld_high_r;
  assign page_wr_en   = ld_wr_r;
  assign pc_inc       = pc_inc_r;

  // serial output changes on the test clock fall, lsb of the active path
  logic tdo_r, tdo_oe_r;
  wire  dr_bit = sel_reset  ? chain_r :
                 sel_unlock ? unlock_sr_r[0] :
                 (sel_cmd | sel_byte) ? cmd_sr_r[0] : bypass_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r    <= (tap_state == jfp_pkg::SHIFT_IR) ? ir_sr_r[0] : dr_bit;
      tdo_oe_r <= (tap_state == jfp_pkg::SHIFT_IR) || (tap_state == jfp_pkg::SHIFT_DR);
    end
  end

  assign tdo    = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_port_lockout: assert property (!port_active |=> in_reset)
    else $error("tap not parked while port locked");

  a_disable_clear: assert property (
    (dis_r && ext_low && !cpu_disable_wr && dis_cnt_r == 2'h0) ##1 (ext_low && !cpu_disable_wr)
    |=> !dis_r)
    else $error("disable bit not cleared after two clocks");

  a_chain_reset: assert property (chain_r |-> target_reset)
    else $error("chain high but target not in reset");

  a_reset_timeout: assert property (
    ($fell(chain_r) && !ext_low && tmo_sel > 12'h002) |-> target_reset [*3])
    else $error("target left reset before time-out");

  a_unlock_match: assert property (
    (do_up_dr && sel_unlock && sig_match && port_active) |=> prog_r)
    else $error("valid signature did not unlock");

  a_unlock_miss: assert property (
    (do_up_dr && sel_unlock && !sig_match) |=> !prog_r)
    else $error("wrong signature unlocked");

  a_por_clear: assert property (@(posedge ref_clk) disable iff (1'b0)
    srst |=> unlock_sr_r == jfp_pkg::UNLOCK_RESET_VAL)
    else $error("unlock register not cleared at reset");

  a_locked_quiet: assert property (!prog_r |=> !flash_cmd_clk && !page_wr_en)
    else $error("locked port produced flash activity");

  a_load_write: assert property (
    ld_update |-> ##2 (page_wr_en && page_wr_data == $past(cmd_sr_r[7:0], 2)))
    else $error("page byte not written after update");

  a_read_step: assert property ((rd_cap && rd_high_r) |=> pc_inc)
    else $error("no counter step after high byte read");

  a_first_noinc: assert property ((ld_step_r && ld_first_r) |=> !pc_inc)
    else $error("counter stepped before first load");

endmodule
`default_nettype wire

// ### verification/jfp_prog_model.sv
// behavioural scan-port programmer that walks the test access port
`timescale 1ns/1ps
`default_nettype none
module jfp_prog_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  time shift_t;  // rise time of the last shifted bit
  time upd_t;    // rise time of the last update
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 200 ns test clock; parks low so the link stands still between frames
  task automatic pulse(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #100;
    tck = 1'b1;  // 5 MHz stays below the chip clock
    #50;
    o = tdo;  // sampled mid-high, tdo only moves after the fall
    #50;
    tck = 1'b0;
  endtask
  task automatic idle(input int n);
    logic o;
    repeat (n) pulse(1'b0, 1'b0, o);
  endtask
  // five ones reach test-logic-reset from anywhere, then park in idle
  task automatic tap_reset();
    logic o;
    repeat (5) pulse(1'b1, 1'b0, o);
    pulse(1'b0, 1'b0, o);
  endtask
  // one full scan from idle back to idle; dout holds what came out
  task automatic scan(input logic is_ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic o;
    dout = 16'h0000;
    pulse(1'b1, 1'b0, o);
    if (is_ir) begin
      pulse(1'b1, 1'b0, o);
    end
    pulse(1'b0, 1'b0, o);
    pulse(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      shift_t = $time + 100;
      pulse(i == n - 1, din[i], o);  // least significant bit first
      dout[i] = o;
    end
    pulse(1'b1, ~din[n-1], o);  // data line no longer shows the last bit
    upd_t = $time + 100;  // this rise is taken in the update state
    pulse(1'b0, ~din[n-1], o);
  endtask
  // the target goes into reset before the signature is sent
  task automatic enter_prog(input logic [15:0] sig);
    logic [15:0] d;
    tap_reset();
    scan(1'b1, 4, 16'h000C, d);
    scan(1'b0, 1, 16'h0001, d);
    scan(1'b1, 4, 16'h0004, d);
    scan(1'b0, 16, sig, d);
  endtask
  // leaving clears the unlock register, then frees the target
  task automatic leave_prog();
    logic [15:0] d;
    scan(1'b1, 4, 16'h0004, d);
    scan(1'b0, 16, 16'h0000, d);
    scan(1'b1, 4, 16'h000C, d);
    scan(1'b0, 1, 16'h0000, d);
  endtask
endmodule
`default_nettype wire

// ### verification/jfp_prog_port_test.sv
// self-checking bench for the scan-port flash programming front end
`timescale 1ns/1ps
`default_nettype none
module jfp_prog_port_test;
  logic        ref_clk, srst, tck, tms, tdi, tdo, tdo_oe, ext_reset_n, en_fuse;
  logic [1:0]  clk_opt;
  logic        dis_wr, dis_wd, dis_bit, tgt_rst, prog_mode, cmd_clk;
  logic [14:0] cmd_res, cmd;
  logic [7:0]  wr_data, w_data;
  logic        wr_high, wr_en, pc_inc, w_high;
  logic [15:0] rd_word;
  int          err_total, comparisons, cmd_clks, pcs, wrs, w_pcs, oes;
  int          seed = 12;
  time         w_t;

  jfp_prog_model m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jfp_prog_port uut (.ref_clk(ref_clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .ext_reset_n(ext_reset_n), .scan_port_enable_fuse(en_fuse),
    .clock_option_fuse(clk_opt), .cpu_disable_wr(dis_wr), .cpu_disable_wdata(dis_wd),
    .scan_port_disable_bit(dis_bit), .target_reset(tgt_rst), .prog_mode(prog_mode),
    .flash_cmd_result(cmd_res), .flash_cmd(cmd), .flash_cmd_clk(cmd_clk),
    .page_wr_data(wr_data), .page_wr_high(wr_high), .page_wr_en(wr_en),
    .flash_rd_word(rd_word), .pc_inc(pc_inc));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // pulse counters and the last page write, tallied on every clock
  always @(posedge ref_clk) begin
    cmd_clks += int'(cmd_clk === 1'b1);
    pcs += int'(pc_inc === 1'b1);
    oes += int'(tdo_oe === 1'b1);
    if (wr_en === 1'b1) begin
      wrs++;
      w_data = wr_data;
      w_high = wr_high;
      w_pcs = pcs;
      w_t = $time;
    end
  end

  // reset time-out in clock cycles for each clock option
  function automatic int tmo(input int opt);
    return 40 << (2 * opt);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_in(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("ERROR at %0t: %s %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // generous bound: the sequence needs well under a millisecond
  initial begin
    #2_000_000;
    err_total++;
    results();
  end

  initial begin
    logic [15:0] d, r, c;
    int n, k0, b;
    srst = 1'b1; ext_reset_n = 1'b1; en_fuse = 1'b1; clk_opt = 2'h0;
    dis_wr = 1'b0; dis_wd = 1'b0; cmd_res = 15'h0000; rd_word = 16'h0000;
    step(12);
    srst = 1'b0;
    step(4);
    chk(prog_mode, 1'b0, "locked after reset");
    m.tap_reset();
    m.scan(1'b1, 4, 16'h000F, d);
    chk(d, 16'h0001, "ir capture");
    // output drive spans exactly the four shift bits, eight clocks each
    chk(16'(oes), 16'h0020, "drive window cycles");
    // commands before unlocking must not reach the flash
    m.scan(1'b1, 4, 16'h0005, d);
    m.scan(1'b0, 15, 16'h2AAA, d);
    m.idle(2);
    chk(cmd, 15'h0000, "command while locked");
    chk(16'(cmd_clks), 16'h0000, "clocks while locked");
    // reset chain hold and release for every time-out option
    m.scan(1'b1, 4, 16'h000C, d);
    for (int opt = 0; opt < 4; opt++) begin
      step(1);
      clk_opt = 2'(opt);
      m.scan(1'b0, 1, 16'h0001, d);
      chk(tgt_rst, 1'b1, "held by chain");
      m.scan(1'b0, 1, 16'h0000, d);
      n = 0;
      while (tgt_rst !== 1'b0 && n < 4000) begin
        step(1);
        n++;
      end
      chk_in(int'(($time - m.shift_t) / 25), tmo(opt), tmo(opt) + 8, "time-out");
    end
    // near-miss signature is refused, the exact one unlocks
    b = $random(seed);
    m.enter_prog(16'hA370 ^ (16'h0001 << b[3:0]));
    chk(prog_mode, 1'b0, "near-miss signature");
    m.enter_prog(16'hA370);
    chk(prog_mode, 1'b1, "good signature");
    // commands: old result out, new command in, one clock per idle rise
    m.scan(1'b1, 4, 16'h0005, d);
    repeat (3) begin
      step(1);
      r = 16'($random(seed));
      c = 16'($random(seed));
      cmd_res = r[14:0];
      m.scan(1'b0, 15, c, d);
      chk(d, {1'b0, r[14:0]}, "command result");
      chk(cmd, c[14:0], "applied command");
      n = cmd_clks;
      m.idle(2);
      step(4);
      chk(16'(cmd_clks - n), 16'h0002, "command clocks");
    end
    // page load: lanes alternate, counter steps with later low bytes
    m.scan(1'b1, 4, 16'h0006, d);
    n = wrs;
    k0 = pcs;
    for (int k = 0; k < 4; k++) begin
      r = 16'($random(seed));
      m.scan(1'b0, 8, r, d);
      // the write pulse lands two clocks after the update rise is taken
      step(3);
      chk(16'(wrs - n), 16'(k + 1), "write count");
      chk(w_data, r[7:0], "written byte");
      chk(w_high, k[0], "write lane");
      chk(16'(w_pcs - k0), 16'(k / 2), "steps before write");
      chk_in(int'((w_t - m.upd_t) / 25), 0, 88, "write delay");
    end
    // page read: low then high, counter steps after each high byte
    m.scan(1'b1, 4, 16'h0007, d);
    k0 = pcs;
    for (int k = 0; k < 4; k++) begin
      step(1);
      r = 16'($random(seed));
      rd_word = r;
      m.scan(1'b0, 8, 16'h0000, d);
      chk(d, {8'h00, k[0] ? r[15:8] : r[7:0]}, "read byte");
      chk(16'(pcs - k0), 16'((k + 1) / 2), "steps after read");
    end
    // software disable locks the port and drops programming mode
    step(1);
    dis_wr = 1'b1;
    dis_wd = 1'b1;
    step(1);
    dis_wr = 1'b0;
    step(2);
    chk(dis_bit, 1'b1, "disable bit set");
    chk(prog_mode, 1'b0, "locked by disable bit");
    ext_reset_n = 1'b0;
    step(2);
    chk(dis_bit, 1'b1, "not cleared early");
    step(4);
    chk(dis_bit, 1'b0, "cleared by reset pin");
    chk(tgt_rst, 1'b1, "held by reset pin");
    ext_reset_n = 1'b1;
    en_fuse = 1'b0;
    m.enter_prog(16'hA370);
    chk(prog_mode, 1'b0, "fuse unprogrammed");
    step(1);
    en_fuse = 1'b1;
    m.enter_prog(16'hA370);
    chk(prog_mode, 1'b1, "usable again");
    m.leave_prog();
    chk(prog_mode, 1'b0, "left programming");
    results();
  end
endmodule
`default_nettype wire
